// >>> rtl/ptpcfg_pkg.sv
`default_nettype none
package ptpcfg_pkg;
    // Bus geometry and message field widths
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned ADDR_BITS = 48;
    localparam int unsigned TIME_W = 64;
    localparam int unsigned SEQ_W = 16;

    // Byte offsets of the register words
    localparam logic [9:0] AUX_HI_OFFSET = 10'h18C;
    localparam logic [9:0] AUX_LO_OFFSET = 10'h190;
    localparam logic [9:0] CONFIG_OFFSET = 10'h194;
    localparam logic [9:0] IRQ_STATUS_OFFSET = 10'h198;
    localparam logic [9:0] IRQ_MASK_OFFSET = 10'h19C;
    localparam logic [9:0] CAPTURE_BASE_OFFSET = 10'h1A0;
    localparam logic [9:0] CAPTURE_SPAN = 10'h040;

    // Words inside one capture slot
    localparam logic [1:0] CAP_WORD_CLK_LO = 2'h0;
    localparam logic [1:0] CAP_WORD_CLK_HI = 2'h1;
    localparam logic [1:0] CAP_WORD_UUID_LO = 2'h2;
    localparam logic [1:0] CAP_WORD_SEQ_UUID_HI = 2'h3;

    // Configuration and auxiliary word reset values and writable bits
    localparam logic [31:0] CONFIG_RESET = 32'h4343_0000;
    localparam logic [31:0] CONFIG_WRITE_MASK = 32'hFFFF_0000;
    localparam logic [31:0] AUX_HI_MASK = 32'h0000_FFFF;
    localparam logic [15:0] AUX_HI_RESET = 16'h0000;
    localparam logic [31:0] AUX_LO_RESET = 32'h0000_0000;

    // Each port owns one byte of the configuration word
    localparam int PORT2_FIELD_LSB = 24;
    localparam int PORT1_FIELD_LSB = 16;
    localparam int PORT_FIELD_W = 8;
    localparam int FLD_ROLE = 7;
    localparam int FLD_PRI = 6;
    localparam int FLD_ALT1 = 5;
    localparam int FLD_ALT2 = 4;
    localparam int FLD_ALT3 = 3;
    localparam int FLD_USER = 2;
    localparam int FLD_LOCK_RX = 1;
    localparam int FLD_LOCK_TX = 0;

    // Enable vector order seen by the address matcher
    localparam int ENA_W = 5;
    localparam int ENA_PRI = 4;
    localparam int ENA_ALT1 = 3;
    localparam int ENA_ALT2 = 2;
    localparam int ENA_ALT3 = 1;
    localparam int ENA_USER = 0;

    // Fixed PTP multicast destinations
    localparam logic [47:0] ADDR_PRIMARY = 48'h0100_5E00_0181;
    localparam logic [47:0] ADDR_ALT1 = 48'h0100_5E00_0182;
    localparam logic [47:0] ADDR_ALT2 = 48'h0100_5E00_0183;
    localparam logic [47:0] ADDR_ALT3 = 48'h0100_5E00_0184;

    // Interrupt status bit = capture slot index
    localparam int IRQ_W = 4;
    localparam int IRQ_P1_RX = 0;
    localparam int IRQ_P1_TX = 1;
    localparam int IRQ_P2_RX = 2;
    localparam int IRQ_P2_TX = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } ptpcfg_bus_state_type;

    function automatic int port_field_lsb(input int port);
        return (port == 2) ? PORT2_FIELD_LSB : PORT1_FIELD_LSB;
    endfunction
endpackage
`default_nettype wire

// >>> rtl/ptpcfg_match_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ptpcfg_match_if;
    logic [47:0] dest;
    logic [4:0] enables;
    logic [47:0] aux_addr;
    logic match;
    modport matcher (input dest, input enables, input aux_addr, output match);
    modport user (output dest, output enables, output aux_addr, input match);
endinterface
`default_nettype wire

// >>> rtl/ptpcfg_addr_match.sv
`timescale 1ns/100ps
`default_nettype none
module ptpcfg_addr_match (
    ptpcfg_match_if.matcher m // Destination, enables and verdict
);
    import ptpcfg_pkg::*;

    wire logic hit_pri;
    wire logic hit_alt1;
    wire logic hit_alt2;
    wire logic hit_alt3;
    wire logic hit_user;

    assign hit_pri = m.enables[ENA_PRI] && (m.dest == ADDR_PRIMARY);
    assign hit_alt1 = m.enables[ENA_ALT1] && (m.dest == ADDR_ALT1);
    assign hit_alt2 = m.enables[ENA_ALT2] && (m.dest == ADDR_ALT2);
    assign hit_alt3 = m.enables[ENA_ALT3] && (m.dest == ADDR_ALT3);
    assign hit_user = m.enables[ENA_USER] && (m.dest == m.aux_addr);
    // Any enabled address may hit; they are not exclusive
    assign m.match = hit_pri | hit_alt1 | hit_alt2 | hit_alt3 | hit_user;
endmodule // ptpcfg_addr_match
`default_nettype wire

// >>> rtl/ptpcfg_top.sv
`timescale 1ns/100ps
`default_nettype none
module ptpcfg_top (
    input wire logic I_CLK, // System clock
    input wire logic I_RESET_N, // Asynchronous reset, active low
    input wire logic [ptpcfg_pkg::ADDR_W-1:0] I_AVS_ADDRESS, // Byte address
    input wire logic I_AVS_READ, // Read request
    input wire logic I_AVS_WRITE, // Write request
    input wire logic [ptpcfg_pkg::BE_W-1:0] I_AVS_BYTEENABLE, // Write byte lanes
    input wire logic [ptpcfg_pkg::DATA_W-1:0] I_AVS_WRITEDATA, // Write data
    output logic [ptpcfg_pkg::DATA_W-1:0] O_AVS_READDATA, // Read data
    output logic O_AVS_WAITREQUEST, // Stall the master
    output logic O_IRQ, // Level interrupt
    input wire logic [ptpcfg_pkg::TIME_W-1:0] I_CLOCK_TIME, // Running PTP clock
    input wire logic I_P1_MSG_VALID, // Port 1 message seen
    input wire logic I_P1_MSG_IS_TX, // Port 1 message is transmit
    input wire logic I_P1_MSG_IS_SYNC, // Port 1 Sync, else Delay_Req
    input wire logic [ptpcfg_pkg::ADDR_BITS-1:0] I_P1_MSG_DEST, // Port 1 destination
    input wire logic [ptpcfg_pkg::ADDR_BITS-1:0] I_P1_MSG_UUID, // Port 1 source UUID
    input wire logic [ptpcfg_pkg::SEQ_W-1:0] I_P1_MSG_SEQ, // Port 1 sequence ID
    input wire logic I_P2_MSG_VALID, // Port 2 message seen
    input wire logic I_P2_MSG_IS_TX, // Port 2 message is transmit
    input wire logic I_P2_MSG_IS_SYNC, // Port 2 Sync, else Delay_Req
    input wire logic [ptpcfg_pkg::ADDR_BITS-1:0] I_P2_MSG_DEST, // Port 2 destination
    input wire logic [ptpcfg_pkg::ADDR_BITS-1:0] I_P2_MSG_UUID, // Port 2 source UUID
    input wire logic [ptpcfg_pkg::SEQ_W-1:0] I_P2_MSG_SEQ, // Port 2 sequence ID
    output logic O_P1_MASTER, // Port 1 acts as clock master
    output logic O_P2_MASTER // Port 2 acts as clock master
);
    import ptpcfg_pkg::*;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic int cap_index(input int port, input int is_tx);
        return (port - 1) * 2 + is_tx;
    endfunction

    // Registers
    logic [31:0] config_q;
    logic [31:0] config_d;
    logic [15:0] aux_hi_q;
    logic [15:0] aux_hi_d;
    logic [31:0] aux_lo_q;
    logic [31:0] aux_lo_d;
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_status_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_mask_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    ptpcfg_bus_state_type bus_q;
    ptpcfg_bus_state_type bus_d;

    // Capture storage, one slot per port and direction
    logic [TIME_W-1:0] cap_clk_q [0:3];
    logic [ADDR_BITS-1:0] cap_uuid_q [0:3];
    logic [SEQ_W-1:0] cap_seq_q [0:3];

    // Per-port message view
    logic msg_valid [1:2];
    logic msg_is_tx [1:2];
    logic msg_is_sync [1:2];
    logic [ADDR_BITS-1:0] msg_dest [1:2];
    logic [ADDR_BITS-1:0] msg_uuid [1:2];
    logic [SEQ_W-1:0] msg_seq [1:2];
    logic [PORT_FIELD_W-1:0] port_fld [1:2];
    logic ptp_hit [1:2];
    logic cap_evt [1:2];

    logic [IRQ_W-1:0] cap_set;
    logic [IRQ_W-1:0] cap_lock;
    logic [IRQ_W-1:0] cap_store;
    logic [IRQ_W-1:0] irq_clr;

    assign msg_valid[1] = I_P1_MSG_VALID;
    assign msg_is_tx[1] = I_P1_MSG_IS_TX;
    assign msg_is_sync[1] = I_P1_MSG_IS_SYNC;
    assign msg_dest[1] = I_P1_MSG_DEST;
    assign msg_uuid[1] = I_P1_MSG_UUID;
    assign msg_seq[1] = I_P1_MSG_SEQ;
    assign msg_valid[2] = I_P2_MSG_VALID;
    assign msg_is_tx[2] = I_P2_MSG_IS_TX;
    assign msg_is_sync[2] = I_P2_MSG_IS_SYNC;
    assign msg_dest[2] = I_P2_MSG_DEST;
    assign msg_uuid[2] = I_P2_MSG_UUID;
    assign msg_seq[2] = I_P2_MSG_SEQ;

    // Bus decode
    wire logic bus_req;
    wire logic wr_commit;
    wire logic [9:0] word_addr;
    wire logic [9:0] cap_off;
    wire logic in_cap;
    wire logic [1:0] cap_sel;
    wire logic [1:0] cap_word;
    wire logic wr_config;
    wire logic wr_aux_hi;
    wire logic wr_aux_lo;
    wire logic wr_status;
    wire logic wr_mask;

    assign bus_req = I_AVS_READ | I_AVS_WRITE;
    // Every access answers in the cycle after it is seen
    assign O_AVS_WAITREQUEST = bus_req && (bus_q == BUS_IDLE);
    assign wr_commit = I_AVS_WRITE && (bus_q == BUS_ANSWER);
    assign word_addr = {I_AVS_ADDRESS[9:2], 2'h0};
    assign cap_off = word_addr - CAPTURE_BASE_OFFSET;
    assign in_cap = (word_addr >= CAPTURE_BASE_OFFSET) && (cap_off < CAPTURE_SPAN);
    assign cap_sel = cap_off[5:4];
    assign cap_word = cap_off[3:2];
    assign wr_config = wr_commit && (word_addr == CONFIG_OFFSET);
    assign wr_aux_hi = wr_commit && (word_addr == AUX_HI_OFFSET);
    assign wr_aux_lo = wr_commit && (word_addr == AUX_LO_OFFSET);
    assign wr_status = wr_commit && (word_addr == IRQ_STATUS_OFFSET);
    assign wr_mask = wr_commit && (word_addr == IRQ_MASK_OFFSET);

    // Register next values; the low half of the configuration word reads zero
    assign config_d = wr_config ?
        (merge_bytes(config_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE) & CONFIG_WRITE_MASK) :
        config_q;
    // Only the low half exists; the upper lanes are dropped on purpose
    assign aux_hi_d = wr_aux_hi ?
        16'(merge_bytes({16'h0000, aux_hi_q}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE)) :
        aux_hi_q;
    assign aux_lo_d = wr_aux_lo ?
        merge_bytes(aux_lo_q, I_AVS_WRITEDATA, I_AVS_BYTEENABLE) :
        aux_lo_q;
    assign irq_mask_d = wr_mask ?
        4'(merge_bytes({28'h000_0000, irq_mask_q}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE)) :
        irq_mask_q;
    assign irq_clr = (wr_status && I_AVS_BYTEENABLE[0]) ? I_AVS_WRITEDATA[3:0] : 4'h0;
    // A capture in the clearing cycle keeps its bit set
    assign irq_status_d = (irq_status_q & ~irq_clr) | cap_set;

    // Answer state lasts one cycle, so every access costs exactly one wait cycle
    always_comb begin
        case (bus_q)
            BUS_IDLE: bus_d = bus_req ? BUS_ANSWER : BUS_IDLE;
            BUS_ANSWER: bus_d = BUS_IDLE;
            default: bus_d = BUS_IDLE;
        endcase
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (in_cap) begin
            case (cap_word)
                CAP_WORD_CLK_LO: rdata_d = cap_clk_q[cap_sel][31:0];
                CAP_WORD_CLK_HI: rdata_d = cap_clk_q[cap_sel][63:32];
                CAP_WORD_UUID_LO: rdata_d = cap_uuid_q[cap_sel][31:0];
                CAP_WORD_SEQ_UUID_HI: rdata_d = {cap_seq_q[cap_sel], cap_uuid_q[cap_sel][47:32]};
                default: rdata_d = 32'h0000_0000;
            endcase
        end else begin
            case (word_addr)
                AUX_HI_OFFSET: rdata_d = {16'h0000, aux_hi_q};
                AUX_LO_OFFSET: rdata_d = aux_lo_q;
                CONFIG_OFFSET: rdata_d = config_q;
                IRQ_STATUS_OFFSET: rdata_d = {28'h000_0000, irq_status_q};
                IRQ_MASK_OFFSET: rdata_d = {28'h000_0000, irq_mask_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            bus_q <= BUS_IDLE;
            rdata_q <= 32'h0000_0000;
        end else begin
            bus_q <= bus_d;
            // Sampled one cycle before the answer edge
            if (bus_q == BUS_IDLE && I_AVS_READ) begin
                rdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            config_q <= CONFIG_RESET;
            aux_hi_q <= AUX_HI_RESET;
            aux_lo_q <= AUX_LO_RESET;
            irq_status_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
        end else begin
            config_q <= config_d;
            aux_hi_q <= aux_hi_d;
            aux_lo_q <= aux_lo_d;
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // Per-port classification and role
    for (genvar p = 1; p <= 2; p++) begin : gen_port
        ptpcfg_match_if mif ();

        assign port_fld[p] = config_q[port_field_lsb(p) +: PORT_FIELD_W];
        assign mif.dest = msg_dest[p];
        assign mif.enables = port_fld[p][FLD_PRI:FLD_USER];
        assign mif.aux_addr = {aux_hi_q, aux_lo_q};
        assign ptp_hit[p] = mif.match;

        ptpcfg_addr_match u_match (
            .m(mif.matcher)
        );

        // Master wants Sync out and Delay_Req in; slave the reverse
        assign cap_evt[p] = msg_valid[p] && ptp_hit[p] &&
            (msg_is_tx[p] ^ msg_is_sync[p] ^ port_fld[p][FLD_ROLE]);
    end

    // Per-slot capture with lock
    for (genvar c = 0; c < 4; c++) begin : gen_slot
        localparam int SP = c / 2 + 1;
        localparam int SDIR = c % 2;

        assign cap_set[c] = cap_evt[SP] &&
            ((SDIR == 1) ? msg_is_tx[SP] : !msg_is_tx[SP]);
        assign cap_lock[c] = port_fld[SP][(SDIR == 1) ? FLD_LOCK_TX : FLD_LOCK_RX];
        // Locked slot holds while its flag stays pending; a same-cycle clear frees it
        assign cap_store[c] = cap_set[c] &&
            !(cap_lock[c] && irq_status_q[c] && !irq_clr[c]);

        always_ff @(posedge I_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
                cap_clk_q[c] <= 64'h0000_0000_0000_0000;
                cap_uuid_q[c] <= 48'h0000_0000_0000;
                cap_seq_q[c] <= 16'h0000;
            end else if (cap_store[c]) begin
                cap_clk_q[c] <= I_CLOCK_TIME;
                cap_uuid_q[c] <= msg_uuid[SP];
                cap_seq_q[c] <= msg_seq[SP];
            end
        end
    end

    assign O_AVS_READDATA = rdata_q;
    assign O_IRQ = |(irq_status_q & irq_mask_q);
    assign O_P1_MASTER = port_fld[1][FLD_ROLE];
    assign O_P2_MASTER = port_fld[2][FLD_ROLE];
endmodule // ptpcfg_top
`default_nettype wire

// >>> tb/ptpcfg_props.sv
`timescale 1ns/100ps
`default_nettype none
module ptpcfg_props (
    input wire logic I_CLK, // Clock
    input wire logic I_RESET_N, // Reset, active low
    input wire logic [ptpcfg_pkg::ADDR_W-1:0] I_AVS_ADDRESS, // Address
    input wire logic I_AVS_READ, // Read
    input wire logic I_AVS_WRITE, // Write
    input wire logic [ptpcfg_pkg::BE_W-1:0] I_AVS_BYTEENABLE, // Lanes
    input wire logic [ptpcfg_pkg::DATA_W-1:0] I_AVS_WRITEDATA, // Write data
    input wire logic O_AVS_WAITREQUEST, // Stall
    input wire logic O_IRQ, // Interrupt
    input wire logic I_P1_MSG_VALID, // Port 1 message
    input wire logic I_P2_MSG_VALID, // Port 2 message
    input wire logic O_P1_MASTER, // Port 1 role
    input wire logic O_P2_MASTER // Port 2 role
);
    import ptpcfg_pkg::*;
    logic req;
    logic wr_done;
    logic cfg_wr;
    assign req = I_AVS_READ | I_AVS_WRITE;
    assign wr_done = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
    assign cfg_wr = wr_done & (I_AVS_ADDRESS[9:2] == CONFIG_OFFSET[9:2]);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    a_one_wait_cycle: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("answer not one cycle after request");
    a_idle_no_stall: assert property (!req |-> !O_AVS_WAITREQUEST)
        else $error("stall without request");
    a_next_req_waits: assert property (req && !O_AVS_WAITREQUEST |=> !req || O_AVS_WAITREQUEST)
        else $error("request answered without wait cycle");
    a_p2_role_write: assert property (cfg_wr && I_AVS_BYTEENABLE[3] |=>
        O_P2_MASTER == $past(I_AVS_WRITEDATA[31])) else $error("port 2 role not written");
    a_p1_role_write: assert property (cfg_wr && I_AVS_BYTEENABLE[2] |=>
        O_P1_MASTER == $past(I_AVS_WRITEDATA[23])) else $error("port 1 role not written");
    a_role_held: assert property (!cfg_wr |=> $stable({O_P1_MASTER, O_P2_MASTER}))
        else $error("role changed without config write");
    a_role_reset: assert property ($rose(I_RESET_N) |-> !O_P1_MASTER && !O_P2_MASTER)
        else $error("role not slave after reset");
    a_irq_rise_cause: assert property ($rose(O_IRQ) |->
        $past(I_P1_MSG_VALID || I_P2_MSG_VALID || wr_done)) else $error("interrupt without cause");
    a_irq_fall_cause: assert property ($fell(O_IRQ) |-> $past(wr_done))
        else $error("interrupt dropped without write");
    c_cfg_write: cover property (cfg_wr);
    c_irq_rise: cover property ($rose(O_IRQ));
    c_p2_master: cover property ($rose(O_P2_MASTER));
endmodule // ptpcfg_props
`default_nettype wire

// >>> tb/ptpcfg_peer.sv
`timescale 1ns/100ps
`default_nettype none
module ptpcfg_peer (
    input wire logic i_clk, // System clock
    output logic o_valid, // Message pulse
    output logic o_is_tx, // Transmit direction
    output logic o_is_sync, // Sync, else Delay_Req
    output logic [47:0] o_dest, // Destination
    output logic [47:0] o_uuid, // Source UUID
    output logic [15:0] o_seq // Sequence ID
);
    initial begin
        o_valid = 1'b0;
        o_is_tx = 1'b0;
        o_is_sync = 1'b0;
        o_dest = 48'h0000_0000_0000;
        o_uuid = 48'h0000_0000_0000;
        o_seq = 16'h0000;
    end
    // Fields are inverted after the pulse so a stale value never passes for a live one
    task automatic send(input logic tx, input logic sy, input logic [47:0] d, input logic [47:0] u);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_is_tx <= tx;
        o_is_sync <= sy;
        o_dest <= d;
        o_uuid <= u;
        o_seq <= u[47:32];
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_is_tx <= ~tx;
        o_is_sync <= ~sy;
        o_dest <= ~d;
        o_uuid <= ~u;
        o_seq <= ~u[47:32];
    endtask
endmodule // ptpcfg_peer
`default_nettype wire

// >>> tb/ptpcfg_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ptpcfg_tb_top;
    import ptpcfg_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic [9:0] I_AVS_ADDRESS = 10'h000;
    logic I_AVS_READ = 1'b0;
    logic I_AVS_WRITE = 1'b0;
    logic [3:0] I_AVS_BYTEENABLE = 4'hF;
    logic [31:0] I_AVS_WRITEDATA = 32'h0000_0000;
    logic [63:0] I_CLOCK_TIME = 64'h0000_0000_0000_0000;
    logic [31:0] O_AVS_READDATA;
    logic O_AVS_WAITREQUEST, O_IRQ, O_P1_MASTER, O_P2_MASTER;
    logic I_P1_MSG_VALID, I_P1_MSG_IS_TX, I_P1_MSG_IS_SYNC;
    logic I_P2_MSG_VALID, I_P2_MSG_IS_TX, I_P2_MSG_IS_SYNC;
    logic [47:0] I_P1_MSG_DEST, I_P1_MSG_UUID, I_P2_MSG_DEST, I_P2_MSG_UUID;
    logic [15:0] I_P1_MSG_SEQ, I_P2_MSG_SEQ;
    logic [31:0] exp_q[$];
    logic [47:0] dst [5];
    logic [31:0] ua, ub;
    int errors = 0;
    int check_count = 0;
    always #50 I_CLK = ~I_CLK;
    always @(posedge I_CLK) I_CLOCK_TIME <= I_CLOCK_TIME + 64'h1;
    ptpcfg_top DUT (.*);
    ptpcfg_peer peer_p1 (.i_clk(I_CLK), .o_valid(I_P1_MSG_VALID), .o_is_tx(I_P1_MSG_IS_TX),
        .o_is_sync(I_P1_MSG_IS_SYNC), .o_dest(I_P1_MSG_DEST), .o_uuid(I_P1_MSG_UUID),
        .o_seq(I_P1_MSG_SEQ));
    ptpcfg_peer peer_p2 (.i_clk(I_CLK), .o_valid(I_P2_MSG_VALID), .o_is_tx(I_P2_MSG_IS_TX),
        .o_is_sync(I_P2_MSG_IS_SYNC), .o_dest(I_P2_MSG_DEST), .o_uuid(I_P2_MSG_UUID),
        .o_seq(I_P2_MSG_SEQ));
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_level(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge I_CLK);
        I_AVS_ADDRESS <= a;
        I_AVS_WRITEDATA <= d;
        I_AVS_WRITE <= wr;
        I_AVS_READ <= ~wr;
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_AVS_WAITREQUEST !== 1'b0 && n < 20);
        I_AVS_WRITE <= 1'b0;
        I_AVS_READ <= 1'b0;
        if (O_AVS_WAITREQUEST !== 1'b0) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // Read data are judged where the answer is sampled, oldest note first
    always @(posedge I_CLK) begin
        if (I_AVS_READ && O_AVS_WAITREQUEST === 1'b0) begin
            chk(O_AVS_READDATA, exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxx_xxxx);
        end
    end
    task automatic probe(input int p, input logic tx, input logic sy, input logic [47:0] d,
        input logic [31:0] e);
        logic [47:0] u;
        logic [63:0] t;
        int s;
        u = {16'($urandom), $urandom};
        s = (p - 1) * 2 + int'(tx);
        if (p == 2) begin
            peer_p2.send(tx, sy, d, u);
        end else begin
            peer_p1.send(tx, sy, d, u);
        end
        // Send returns at the capture edge, before the bench clock advances
        t = I_CLOCK_TIME;
        rd(IRQ_STATUS_OFFSET, e);
        if (e != 32'h0) begin
            rd(CAPTURE_BASE_OFFSET + 10'(s * 16 + 8), u[31:0]);
            rd(CAPTURE_BASE_OFFSET + 10'(s * 16), t[31:0]);
            rd(CAPTURE_BASE_OFFSET + 10'(s * 16 + 12), {u[47:32], u[47:32]});
        end
        wr(IRQ_STATUS_OFFSET, 32'h0000_000F);
    endtask
    initial begin
        void'($urandom(32'h42ff_81da));
        ua = $urandom;
        ub = ~ua;
        repeat (6) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        rd(CONFIG_OFFSET, CONFIG_RESET);
        rd(AUX_LO_OFFSET, 32'h0000_0000);
        wr(AUX_HI_OFFSET, ua);
        wr(AUX_LO_OFFSET, ub);
        rd(AUX_HI_OFFSET, ua & AUX_HI_MASK);
        rd(AUX_LO_OFFSET, ub);
        dst = '{ADDR_PRIMARY, ADDR_ALT1, ADDR_ALT2, ADDR_ALT3, {ua[15:0], ub}};
        for (int i = 0; i < 6; i++) begin
            wr(CONFIG_OFFSET, (i < 5) ? 32'h4000_0000 >> i : 32'h7C00_0000);
            for (int j = 0; j < 5; j++) begin
                probe(2, 1'b0, 1'b1, dst[j], (i == j || i == 5) ? 32'h4 : 32'h0);
            end
        end
        for (int p = 1; p < 3; p++) begin
            for (int k = 0; k < 8; k++) begin
                wr(CONFIG_OFFSET, (32'(k[2]) << (p * 8 + 15)) | (32'h1 << (p * 8 + 14)));
                @(negedge I_CLK);
                chk_level((p == 2) ? O_P2_MASTER : O_P1_MASTER, k[2]);
                probe(p, k[1], k[0], ADDR_PRIMARY,
                    ((k[1] == k[0]) == k[2]) ? 32'h1 << ((p - 1) * 2 + k[1]) : 32'h0);
            end
        end
        wr(CONFIG_OFFSET, 32'h4300_0000);
        peer_p2.send(1'b0, 1'b1, ADDR_PRIMARY, {16'h0, ua});
        peer_p2.send(1'b0, 1'b1, ADDR_PRIMARY, {16'h0, ub});
        rd(10'h1C8, ua);
        peer_p2.send(1'b1, 1'b0, ADDR_PRIMARY, {16'h0, ua});
        peer_p2.send(1'b1, 1'b0, ADDR_PRIMARY, {16'h0, ub});
        rd(10'h1D8, ua);
        wr(CONFIG_OFFSET, 32'h4000_0000);
        peer_p2.send(1'b0, 1'b1, ADDR_PRIMARY, {16'h0, ub});
        peer_p2.send(1'b1, 1'b0, ADDR_PRIMARY, {16'h0, ub});
        rd(10'h1C8, ub);
        rd(10'h1D8, ub);
        rd(IRQ_STATUS_OFFSET, 32'h0000_000C);
        wr(IRQ_MASK_OFFSET, 32'h0000_0008);
        @(negedge I_CLK);
        chk_level(O_IRQ, 1'b1);
        wr(IRQ_STATUS_OFFSET, 32'h0000_0008);
        @(negedge I_CLK);
        chk_level(O_IRQ, 1'b0);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0004);
        rd(10'h3F0, 32'h0000_0000);
        // Only the top lane is enabled, so the port 1 byte must keep its zero
        I_AVS_BYTEENABLE <= 4'h8;
        wr(CONFIG_OFFSET, 32'h8055_AA55);
        I_AVS_BYTEENABLE <= 4'hF;
        @(negedge I_CLK);
        chk_level(O_P2_MASTER, 1'b1);
        rd(CONFIG_OFFSET, 32'h8000_0000);
        wr(CONFIG_OFFSET, 32'hFFFF_FFFF);
        rd(CONFIG_OFFSET, CONFIG_WRITE_MASK);
        @(posedge I_CLK);
        I_RESET_N <= 1'b0;
        repeat (2) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        rd(CONFIG_OFFSET, CONFIG_RESET);
        repeat (3) @(posedge I_CLK);
        tally_and_finish();
    end
endmodule // ptpcfg_tb_top
bind ptpcfg_top ptpcfg_props u_props (.*);
`default_nettype wire
